// ===== glass_model.sv
// Passive glass model that remembers what the first two commons showed.
`timescale 1ns/1ps
module glass_model (
  input  wire logic        clk_sys,
  input  wire logic [3:0]  com_active,
  input  wire logic [28:0] seg_drive,
  output logic      [28:0] lit0,
  output logic      [28:0] lit1
);
  // A segment image is only seen in its own slot, so it is kept after.
  always_ff @(posedge clk_sys) begin
    if (com_active[0]) lit0 <= seg_drive;
    if (com_active[1]) lit1 <= seg_drive;
  end
endmodule

// ===== lcd_asserts.sv
// Concurrent checks on the ports of the segment LCD controller.
`timescale 1ns/1ps
module lcd_checker #(
  parameter int SEGS = 29,
  parameter int COMS = 4
) (
  input wire logic            clk_sys,
  input wire logic            reset,
  input wire logic [7:0]      sfr_addr,
  input wire logic            sfr_wr,
  input wire logic            sfr_rd,
  input wire logic [7:0]      sfr_wdata,
  input wire logic [7:0]      sfr_rdata,
  input wire logic            lcd_tick_2048,
  input wire logic            lcd_tick_128,
  input wire logic            rtc_enable,
  input wire logic            low_power_battery_mode,
  input wire logic [COMS-1:0] com_active,
  input wire logic [SEGS-1:0] seg_drive,
  input wire logic [SEGS-1:0] seg_pin_lcd,
  input wire logic            shared_pin_28_is_com,
  input wire logic            shared_pin_27_is_com,
  input wire logic            drive_invert,
  input wire logic            display_on,
  input wire logic            charge_pump_enable,
  input wire logic            external_ladder_enable,
  input wire logic [5:0]      bias_level
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  // Register writes reach their registered outputs two edges later.
  property p_pin28;
    sfr_wr && sfr_addr == 8'h95 |-> ##2
      shared_pin_28_is_com == ($past(sfr_wdata[1:0], 2) >= 2'h2);
  endproperty
  property p_pin27;
    sfr_wr && sfr_addr == 8'h95 |-> ##2
      shared_pin_27_is_com == ($past(sfr_wdata[1:0], 2) == 2'h3);
  endproperty
  property p_ladder;
    sfr_wr && sfr_addr == 8'h9c |-> ##2
      external_ladder_enable == $past(sfr_wdata[6], 2);
  endproperty
  property p_pump_off;
    sfr_wr && sfr_addr == 8'h95 && !sfr_wdata[7] |-> ##2 !charge_pump_enable;
  endproperty
  // The glass sees at most one common, and none while the display is off.
  property p_onehot;
    $onehot0(com_active);
  endproperty
  property p_com_off;
    !display_on |-> com_active == '0;
  endproperty
  // A new common slot always starts on the positive half of the waveform.
  property p_invert;
    $changed(com_active) && com_active != '0 && $past(com_active) != '0
      |-> !drive_invert;
  endproperty
  // Reserved bits read back as zero.
  property p_ptr_rsv;
    sfr_rd && sfr_addr == 8'hac |=> !sfr_rdata[6];
  endproperty
  property p_upd_rsv;
    sfr_rd && sfr_addr == 8'hb1 |=> sfr_rdata[7:1] == 7'h00;
  endproperty
  // Fixed segment pins stay segments once out of reset.
  property p_fixed;
    !$past(reset) |-> seg_pin_lcd[15:0] == 16'hffff && seg_pin_lcd[26];
  endproperty

  a_pin28: assert property (p_pin28) else $error("pin 28 role wrong");
  a_pin27: assert property (p_pin27) else $error("pin 27 role wrong");
  a_ladder: assert property (p_ladder) else $error("ladder wrong");
  a_pump_off: assert property (p_pump_off) else $error("pump on");
  a_onehot: assert property (p_onehot) else $error("commons clash");
  a_com_off: assert property (p_com_off) else $error("common on");
  a_invert: assert property (p_invert) else $error("slot polarity");
  a_ptr_rsv: assert property (p_ptr_rsv) else $error("pointer bit");
  a_upd_rsv: assert property (p_upd_rsv) else $error("update bits");
  a_fixed: assert property (p_fixed) else $error("fixed segment");

  c_common_line_3: cover property (com_active[3]);
  c_pin27: cover property (shared_pin_27_is_com);
  c_blink: cover property ($fell(display_on));
endmodule

bind segment_lcd_controller lcd_checker #(.SEGS(SEGS), .COMS(COMS))
  u_lcd_checker (.clk_sys(clk_sys), .reset(reset), .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata), .lcd_tick_2048(lcd_tick_2048),
  .lcd_tick_128(lcd_tick_128), .rtc_enable(rtc_enable),
  .low_power_battery_mode(low_power_battery_mode),
  .com_active(com_active), .seg_drive(seg_drive),
  .seg_pin_lcd(seg_pin_lcd), .shared_pin_28_is_com(shared_pin_28_is_com),
  .shared_pin_27_is_com(shared_pin_27_is_com), .drive_invert(drive_invert),
  .display_on(display_on), .charge_pump_enable(charge_pump_enable),
  .external_ladder_enable(external_ladder_enable), .bias_level(bias_level));

// ===== lcd_pkg.sv
// Constants shared by the segment LCD controller and its segment store.
package lcd_pkg;

  // Register addresses on the special function register port.
  localparam logic [7:0] ADDR_MAIN_CONFIG     = 8'h95;
  localparam logic [7:0] ADDR_CLOCK_DIVIDER   = 8'h96;
  localparam logic [7:0] ADDR_SEG_ENABLE_LOW  = 8'h97;
  localparam logic [7:0] ADDR_EXT_CONFIG      = 8'h9c;
  localparam logic [7:0] ADDR_MEM_POINTER     = 8'hac;
  localparam logic [7:0] ADDR_MEM_DATA        = 8'hae;
  localparam logic [7:0] ADDR_UPDATE_CONTROL  = 8'hb1;
  localparam logic [7:0] ADDR_SEG_ENABLE_HIGH = 8'hed;

  // Values after reset of every register.
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // Field positions in lcd_main_config.
  localparam int unsigned MAIN_DISPLAY_ENABLE  = 7;
  localparam int unsigned MAIN_MEMORY_CLEAR    = 6;
  localparam int unsigned MAIN_BATTERY_OFF     = 5;
  localparam int unsigned MAIN_BLINK_ENABLE    = 4;
  localparam int unsigned MAIN_BIAS            = 2;
  localparam int unsigned MAIN_MUX_LSB         = 0;

  // Field positions in lcd_clock_divider.
  localparam int unsigned CLK_BLINK_MODE_LSB   = 6;
  localparam int unsigned CLK_BLINK_FREQ_LSB   = 4;
  localparam int unsigned CLK_FRAME_DIV_LSB    = 0;

  // Field positions in lcd_extended_config.
  localparam int unsigned EXT_CLOCK_SELECT     = 7;
  localparam int unsigned EXT_LADDER_SELECT    = 6;
  localparam int unsigned EXT_BIAS_LEVEL_LSB   = 0;

  // Pointer fields, update freeze bit and reserved masks.
  localparam int unsigned PTR_WRITE_BIT        = 7;
  localparam logic [7:0]  PTR_USED_MASK        = 8'hbf;
  localparam int unsigned UPDATE_FREEZE_BIT    = 0;
  localparam logic [7:0]  UPDATE_USED_MASK     = 8'h01;
  localparam logic [7:0]  SEG_HIGH_USED_MASK   = 8'h0f;

  // Multiplex level codes.
  localparam logic [1:0] MUX_3X = 2'h2;
  localparam logic [1:0] MUX_4X = 2'h3;

  // Blink mode codes.
  localparam logic [1:0] BLINK_SW_OFF    = 2'h0;
  localparam logic [1:0] BLINK_SW_ON     = 2'h1;
  localparam logic [1:0] BLINK_AUTO      = 2'h2;
  localparam logic [1:0] BLINK_AUTO_SLOW = 2'h3;

  // Automatic blink half periods, counted in 128 Hz ticks.
  localparam logic [8:0] BLINK_HALF_F0   = 9'h040;
  localparam logic [8:0] BLINK_HALF_F1   = 9'h020;
  localparam logic [8:0] BLINK_HALF_F2   = 9'h010;
  localparam logic [8:0] BLINK_HALF_F3   = 9'h008;
  localparam logic [8:0] BLINK_HALF_SLOW = 9'h100;

  // Sizes of the segment memory and the glass interface.
  localparam int unsigned SEG_BYTES   = 15;
  localparam int unsigned SEG_LINES   = 29;
  localparam int unsigned COM_LINES   = 4;
  localparam int unsigned FIXED_SEGS  = 16;

endpackage

// ===== segment_lcd_controller.sv
// Segment LCD controller: registers, frame timing, blink and drive.
//
// Operation
// - Multiplex level 2 makes pin 28 common 2.
// - Level 3 adds pin 27 as common 3.
// - Segments 0-15 fixed; 16-25 individually enabled.
// - Clear bit and reset zero the segment memory.
// - Clock select picks 2048 Hz or 128 Hz.
// - Frame rate from clock, mux, frame divider.
// - Polarity inverts at twice common switching rate.
// - Display blinks only while blink enable set.
// - Software blink follows the blink mode field.
// - Automatic blink: five rates, needs running RTC.
// - Fifteen bytes; byte 14 holds only segment 28.
// - Low nibble even segment; bit n is common n.
// - Segment memory kept in battery mode.
// - Pointer write with top bit stores data.
// - Pointer write with top bit clear loads data.
// - Freeze bit holds displayed segments until cleared.
// - Ladder select picks external ladder or pump.
// - Pump off whenever the display is disabled.
// - Ladder select resets to zero.
// - Battery mode shows display only if allowed.
`timescale 1ns/1ps
module segment_lcd_controller #(
  parameter int SEGS = lcd_pkg::SEG_LINES,
  parameter int COMS = lcd_pkg::COM_LINES
) (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic [7:0]        sfr_addr,
  input  wire logic              sfr_wr,
  input  wire logic              sfr_rd,
  input  wire logic [7:0]        sfr_wdata,
  output logic      [7:0]        sfr_rdata,
  input  wire logic              lcd_tick_2048,
  input  wire logic              lcd_tick_128,
  input  wire logic              rtc_enable,
  input  wire logic              low_power_battery_mode,
  output logic      [COMS-1:0]   com_active,
  output logic      [SEGS-1:0]   seg_drive,
  output logic      [SEGS-1:0]   seg_pin_lcd,
  output logic                   shared_pin_28_is_com,
  output logic                   shared_pin_27_is_com,
  output logic                   drive_invert,
  output logic                   display_on,
  output logic                   charge_pump_enable,
  output logic                   external_ladder_enable,
  output logic      [5:0]        bias_level
);

  // Software visible registers.
  logic [7:0] lcd_main_config_reg;
  logic [7:0] lcd_clock_divider_reg;
  logic [7:0] segment_enable_low_reg;
  logic [7:0] segment_enable_high_reg;
  logic [7:0] lcd_extended_config_reg;
  logic [7:0] segment_memory_pointer_reg;
  logic [7:0] segment_memory_data_reg;
  logic [7:0] display_update_control_reg;
  logic [7:0] sfr_rdata_reg;

  // Timing state.
  logic [3:0] half_cnt_reg;
  logic       polarity_reg;
  logic [1:0] com_idx_reg;
  logic [8:0] blink_cnt_reg;
  logic       blink_phase_reg;

  // Registered outputs.
  logic [COMS-1:0] com_active_reg;
  logic [SEGS-1:0] seg_drive_reg;
  logic [SEGS-1:0] seg_pin_lcd_reg;
  logic            pin28_com_reg;
  logic            pin27_com_reg;
  logic            display_on_reg;
  logic            pump_reg;
  logic            ladder_reg;

  // Register decode.
  wire wr_main    = sfr_wr && (sfr_addr == lcd_pkg::ADDR_MAIN_CONFIG);
  wire wr_clkdiv  = sfr_wr && (sfr_addr == lcd_pkg::ADDR_CLOCK_DIVIDER);
  wire wr_seg_lo  = sfr_wr && (sfr_addr == lcd_pkg::ADDR_SEG_ENABLE_LOW);
  wire wr_seg_hi  = sfr_wr && (sfr_addr == lcd_pkg::ADDR_SEG_ENABLE_HIGH);
  wire wr_ext     = sfr_wr && (sfr_addr == lcd_pkg::ADDR_EXT_CONFIG);
  wire wr_pointer = sfr_wr && (sfr_addr == lcd_pkg::ADDR_MEM_POINTER);
  wire wr_data    = sfr_wr && (sfr_addr == lcd_pkg::ADDR_MEM_DATA);
  wire wr_update  = sfr_wr && (sfr_addr == lcd_pkg::ADDR_UPDATE_CONTROL);

  // Configuration fields.
  wire       display_enable  =
    lcd_main_config_reg[lcd_pkg::MAIN_DISPLAY_ENABLE];
  wire       segment_memory_clear =
    lcd_main_config_reg[lcd_pkg::MAIN_MEMORY_CLEAR];
  wire       battery_mode_display_off =
    lcd_main_config_reg[lcd_pkg::MAIN_BATTERY_OFF];
  wire       blink_enable =
    lcd_main_config_reg[lcd_pkg::MAIN_BLINK_ENABLE];
  wire [1:0] multiplex_level =
    lcd_main_config_reg[lcd_pkg::MAIN_MUX_LSB +: 2];
  wire [1:0] blink_mode_field =
    lcd_clock_divider_reg[lcd_pkg::CLK_BLINK_MODE_LSB +: 2];
  wire [1:0] blink_frequency_field =
    lcd_clock_divider_reg[lcd_pkg::CLK_BLINK_FREQ_LSB +: 2];
  wire [3:0] frame_divider =
    lcd_clock_divider_reg[lcd_pkg::CLK_FRAME_DIV_LSB +: 4];
  wire       lcd_clock_select =
    lcd_extended_config_reg[lcd_pkg::EXT_CLOCK_SELECT];
  wire       external_ladder_select =
    lcd_extended_config_reg[lcd_pkg::EXT_LADDER_SELECT];
  wire       update_freeze =
    display_update_control_reg[lcd_pkg::UPDATE_FREEZE_BIT];

  // Segment memory access through the pointer.
  wire       ptr_write_req = sfr_wdata[lcd_pkg::PTR_WRITE_BIT];
  wire [5:0] ptr_addr      = sfr_wdata[5:0];
  wire       mem_wr_en     = wr_pointer && ptr_write_req;
  wire [7:0] mem_rd_data;
  logic [lcd_pkg::SEG_BYTES*8-1:0] shown;

  // The store is written from the data register as it stands, which is
  // why software must load the data before it writes the pointer.
  segment_store #(
    .BYTES (lcd_pkg::SEG_BYTES)
  ) u_store (
    .clk_sys (clk_sys),
    .reset   (reset),
    .clear   (segment_memory_clear),
    .wr_en   (mem_wr_en),
    .wr_addr (ptr_addr),
    .wr_data (segment_memory_data_reg),
    .rd_addr (ptr_addr),
    .rd_data (mem_rd_data),
    .freeze  (update_freeze),
    .shown   (shown)
  );

  // Software visible registers; reserved bits never store.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lcd_main_config_reg        <= lcd_pkg::RESET_BYTE;
      lcd_clock_divider_reg      <= lcd_pkg::RESET_BYTE;
      segment_enable_low_reg     <= lcd_pkg::RESET_BYTE;
      segment_enable_high_reg    <= lcd_pkg::RESET_BYTE;
      lcd_extended_config_reg    <= lcd_pkg::RESET_BYTE;
      segment_memory_pointer_reg <= lcd_pkg::RESET_BYTE;
      display_update_control_reg <= lcd_pkg::RESET_BYTE;
    end else begin
      if (wr_main) begin
        lcd_main_config_reg <= sfr_wdata;
      end
      if (wr_clkdiv) begin
        lcd_clock_divider_reg <= sfr_wdata;
      end
      if (wr_seg_lo) begin
        segment_enable_low_reg <= sfr_wdata;
      end
      if (wr_seg_hi) begin
        segment_enable_high_reg <= sfr_wdata & lcd_pkg::SEG_HIGH_USED_MASK;
      end
      if (wr_ext) begin
        lcd_extended_config_reg <= sfr_wdata;
      end
      if (wr_pointer) begin
        segment_memory_pointer_reg <= sfr_wdata & lcd_pkg::PTR_USED_MASK;
      end
      if (wr_update) begin
        display_update_control_reg <= sfr_wdata & lcd_pkg::UPDATE_USED_MASK;
      end
    end
  end

  // The data register takes software writes, or the addressed memory byte
  // when the pointer is written with its top bit clear.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      segment_memory_data_reg <= lcd_pkg::RESET_BYTE;
    end else if (wr_data) begin
      segment_memory_data_reg <= sfr_wdata;
    end else if (wr_pointer && !ptr_write_req) begin
      segment_memory_data_reg <= mem_rd_data;
    end
  end

  // Read data is registered on the read strobe and holds otherwise.
  logic [7:0] read_mux;
  always_comb begin
    unique case (sfr_addr)
      lcd_pkg::ADDR_MAIN_CONFIG:     read_mux = lcd_main_config_reg;
      lcd_pkg::ADDR_CLOCK_DIVIDER:   read_mux = lcd_clock_divider_reg;
      lcd_pkg::ADDR_SEG_ENABLE_LOW:  read_mux = segment_enable_low_reg;
      lcd_pkg::ADDR_SEG_ENABLE_HIGH: read_mux = segment_enable_high_reg;
      lcd_pkg::ADDR_EXT_CONFIG:      read_mux = lcd_extended_config_reg;
      lcd_pkg::ADDR_MEM_POINTER:     read_mux = segment_memory_pointer_reg;
      lcd_pkg::ADDR_MEM_DATA:        read_mux = segment_memory_data_reg;
      lcd_pkg::ADDR_UPDATE_CONTROL:  read_mux = display_update_control_reg;
      default:                       read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      sfr_rdata_reg <= lcd_pkg::RESET_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata_reg <= read_mux;
    end
  end

  // The LCD timing tick comes from one of the two low rate sources.
  wire       lcd_tick = lcd_clock_select ? lcd_tick_128
                                         : lcd_tick_2048;
  wire [1:0] last_com = (multiplex_level == lcd_pkg::MUX_4X) ? 2'h3 :
                        (multiplex_level == lcd_pkg::MUX_3X) ? 2'h2 :
                        2'h1;
  wire       half_done = lcd_tick && (half_cnt_reg >= frame_divider);

  // Each common slot lasts two halves of frame_divider+1 ticks; the drive
  // polarity flips every half so no slot leaves DC on the glass.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      half_cnt_reg <= 4'h0;
      polarity_reg <= 1'b0;
      com_idx_reg  <= 2'h0;
    end else if (half_done) begin
      half_cnt_reg <= 4'h0;
      polarity_reg <= ~polarity_reg;
      if (polarity_reg) begin
        com_idx_reg <= (com_idx_reg >= last_com) ? 2'h0
                                                 : com_idx_reg + 2'h1;
      end
    end else if (lcd_tick) begin
      half_cnt_reg <= half_cnt_reg + 4'h1;
    end
  end

  // Automatic blink half period chosen by mode and frequency fields.
  logic [8:0] blink_half;
  always_comb begin
    if (blink_mode_field == lcd_pkg::BLINK_AUTO_SLOW) begin
      blink_half = lcd_pkg::BLINK_HALF_SLOW;
    end else begin
      unique case (blink_frequency_field)
        2'h0:    blink_half = lcd_pkg::BLINK_HALF_F0;
        2'h1:    blink_half = lcd_pkg::BLINK_HALF_F1;
        2'h2:    blink_half = lcd_pkg::BLINK_HALF_F2;
        default: blink_half = lcd_pkg::BLINK_HALF_F3;
      endcase
    end
  end

  wire auto_blink = blink_mode_field[1] && rtc_enable;
  wire blink_wrap = lcd_tick_128 && (blink_cnt_reg >= blink_half - 9'h001);

  // The blink counter runs off the RTC rate tick and only while the
  // automatic mode can use it, which keeps the first phase predictable.
  always_ff @(posedge clk_sys) begin
    if (reset || !blink_enable || !auto_blink) begin
      blink_cnt_reg   <= 9'h000;
      blink_phase_reg <= 1'b1;
    end else if (blink_wrap) begin
      blink_cnt_reg   <= 9'h000;
      blink_phase_reg <= ~blink_phase_reg;
    end else if (lcd_tick_128) begin
      blink_cnt_reg   <= blink_cnt_reg + 9'h001;
    end
  end

  // Visibility from blink: software mode follows the field directly; an
  // automatic mode with the RTC stopped leaves the display steady on.
  logic blink_visible;
  always_comb begin
    if (!blink_enable) begin
      blink_visible = 1'b1;
    end else if (!blink_mode_field[1]) begin
      blink_visible = (blink_mode_field == lcd_pkg::BLINK_SW_ON);
    end else if (auto_blink) begin
      blink_visible = blink_phase_reg;
    end else begin
      blink_visible = 1'b1;
    end
  end

  // Display enable qualified by the battery mode permission.
  wire display_allowed = display_enable &&
    !(low_power_battery_mode && battery_mode_display_off);
  wire display_next    = display_allowed && blink_visible;

  // Pin functions: fixed segments, enabled shared pins, and the commons.
  wire pin28_com = (multiplex_level == lcd_pkg::MUX_3X) ||
                   (multiplex_level == lcd_pkg::MUX_4X);
  wire pin27_com = (multiplex_level == lcd_pkg::MUX_4X);
  logic [SEGS-1:0] lcd_fn_next;
  always_comb begin
    lcd_fn_next = '1;
    lcd_fn_next[19:16] = segment_enable_high_reg[3:0];
    lcd_fn_next[25:20] = segment_enable_low_reg[7:2];
    lcd_fn_next[27] = !pin27_com;
    lcd_fn_next[28] = !pin28_com;
  end

  // Each segment reads its nibble bit for the active common.
  logic [SEGS-1:0] seg_next;
  generate
    for (genvar s = 0; s < SEGS; s++) begin : g_seg
      localparam int BASE = (s / 2) * 8 + (s % 2) * 4;
      assign seg_next[s] = display_next && lcd_fn_next[s] &&
                           shown[BASE + int'(com_idx_reg)];
    end
  endgenerate

  // One-hot active common, silent while the display is off.
  logic [COMS-1:0] com_next;
  always_comb begin
    com_next = '0;
    if (display_next) begin
      com_next[com_idx_reg] = 1'b1;
    end
  end

  // Every output leaves through a flip-flop.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      com_active_reg  <= '0;
      seg_drive_reg   <= '0;
      seg_pin_lcd_reg <= '0;
      pin28_com_reg   <= 1'b0;
      pin27_com_reg   <= 1'b0;
      display_on_reg  <= 1'b0;
      pump_reg        <= 1'b0;
      ladder_reg      <= 1'b0;
    end else begin
      com_active_reg  <= com_next;
      seg_drive_reg   <= seg_next;
      seg_pin_lcd_reg <= lcd_fn_next;
      pin28_com_reg   <= pin28_com;
      pin27_com_reg   <= pin27_com;
      display_on_reg  <= display_next;
      // Blinking does not stop the pump; restarting it each phase would
      // cost more than it saves.
      pump_reg        <= display_allowed && !external_ladder_select;
      ladder_reg      <= external_ladder_select;
    end
  end

  assign sfr_rdata              = sfr_rdata_reg;
  assign com_active             = com_active_reg;
  assign seg_drive              = seg_drive_reg;
  assign seg_pin_lcd            = seg_pin_lcd_reg;
  assign shared_pin_28_is_com   = pin28_com_reg;
  assign shared_pin_27_is_com   = pin27_com_reg;
  assign drive_invert           = polarity_reg;
  assign display_on             = display_on_reg;
  assign charge_pump_enable     = pump_reg;
  assign external_ladder_enable = ladder_reg;
  assign bias_level = lcd_extended_config_reg[lcd_pkg::EXT_BIAS_LEVEL_LSB +: 6];

endmodule

// ===== segment_lcd_controller_tb.sv
// Directed testbench for the segment LCD controller.
`timescale 1ns/1ps
module segment_lcd_controller_tb;
  logic        clk_sys, reset, sfr_wr, sfr_rd, t2048, t128, rtc_enable;
  logic        batt, pin28, pin27, inv, display_on, pump, ladder;
  logic        en2048, en128;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, e;
  logic [3:0]  com_active, c;
  logic [28:0] seg_drive, seg_pin_lcd, lit0, lit1;
  logic [5:0]  bias;
  logic [1:0]  tick_cnt = 2'h0;
  int          failures = 0;
  int          checks_done = 0;
  int          n;
  logic [7:0]  addrs [9] = '{8'h95, 8'h96, 8'h97, 8'h9c, 8'hac, 8'hae,
                             8'hb1, 8'hed, 8'h90};

  segment_lcd_controller u_segment_lcd_controller (.clk_sys(clk_sys),
    .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .lcd_tick_2048(t2048),
    .lcd_tick_128(t128), .rtc_enable(rtc_enable),
    .low_power_battery_mode(batt), .com_active(com_active),
    .seg_drive(seg_drive), .seg_pin_lcd(seg_pin_lcd),
    .shared_pin_28_is_com(pin28), .shared_pin_27_is_com(pin27),
    .drive_invert(inv), .display_on(display_on),
    .charge_pump_enable(pump), .external_ladder_enable(ladder),
    .bias_level(bias));
  glass_model u_glass_model (.clk_sys(clk_sys), .com_active(com_active),
    .seg_drive(seg_drive), .lit0(lit0), .lit1(lit1));

  // Clock of 20 ns.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Ticks come every fourth clock so that whole frames fit in a short run.
  always @(posedge clk_sys) begin
    tick_cnt <= tick_cnt + 2'h1;
    t2048 <= #1 en2048 && tick_cnt == 2'h0;
    t128 <= #1 en128 && tick_cnt == 2'h0;
  end

  // One register access; strobes drop one cycle later.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = !w;
    @(posedge clk_sys);
    #1;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic chkv(input logic [28:0] got, input logic [28:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chkv({21'h0, sfr_rdata}, {21'h0, exp});
  endtask
  // Waiting is bounded; a common that never arrives ends the run.
  task automatic wait_com(input logic [3:0] exp);
    int k;
    k = 0;
    while (com_active !== exp && k < 300) begin
      step(1);
      k++;
    end
    chkv({25'h0, com_active}, {25'h0, exp});
    if (k == 300) final_report();
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence: registers, memory, scan, freeze, blink, power.
  initial begin
    {sfr_wr, sfr_rd, sfr_addr, sfr_wdata, batt, en128} = '0;
    rtc_enable = 1'b1;
    en2048 = 1'b1;
    reset = 1'b1;
    step(20);
    reset = 1'b0;
    foreach (addrs[i]) rchk(addrs[i], 8'h00);
    chkv(seg_pin_lcd, 29'h1c00ffff);
    wr(8'hed, 8'hff);
    wr(8'h97, 8'hfc);
    rchk(8'hed, 8'h0f);
    chkv(seg_pin_lcd, 29'h1fffffff);
    wr(8'hb1, 8'hff);
    rchk(8'hb1, 8'h01);
    wr(8'hac, 8'hff);
    rchk(8'hac, 8'hbf);
    // Fill all bytes, then read them back in battery mode.
    for (int b = 0; b < 15; b++) begin
      wr(8'hae, 8'(b * 8'h25 + 8'h05));
      wr(8'hac, 8'h80 | 8'(b));
    end
    batt = 1'b1;
    for (int b = 0; b < 16; b++) begin
      e = b == 15 ? 8'h00 : 8'(b * 8'h25 + 8'h05);
      wr(8'hac, 8'(b));
      acc(1'b0, 8'hae, 8'h00);
      e = b == 14 ? e & 8'h0f : e;
      chkv({21'h0, sfr_rdata & (b == 14 ? 8'h0f : 8'hff)}, {21'h0, e});
    end
    batt = 1'b0;
    wr(8'h95, 8'h40);
    wr(8'h95, 8'h00);
    wr(8'hac, 8'h03);
    rchk(8'hae, 8'h00);
    // Scan every multiplex level through a full frame.
    for (int m = 0; m < 4; m++) begin
      n = m < 2 ? 2 : m + 1;
      wr(8'h95, 8'h00);
      wr(8'h95, 8'h80 | 8'(m));
      wait_com(4'h1);
      chkv({27'h0, pin27, pin28}, {27'h0, m == 3, m >= 2});
      for (int k = 1; k <= n; k++) wait_com(4'(1 << (k % n)));
    end
    chkv(display_on, 1'b1);
    // Frozen copy hides a new byte until the freeze bit is cleared.
    wr(8'hae, 8'h21);
    wr(8'hac, 8'h80);
    for (int k = 0; k < 3; k++) wait_com(4'(2 >> (k % 2)));
    chkv(lit0[1:0], 2'h0);
    wr(8'hb1, 8'h00);
    for (int k = 1; k < 5; k++) wait_com(4'(2 >> (k % 2)));
    chkv(lit0[1:0], 2'h1);
    wait_com(4'h4);
    chkv(lit1[1:0], 2'h2);
    // Software blink follows the mode field; auto blink needs the RTC running.
    wr(8'h95, 8'h93);
    step(2);
    chkv(display_on, 1'b0);
    wr(8'h96, 8'h40);
    step(2);
    chkv(display_on, 1'b1);
    en128 = 1'b1;
    wr(8'h96, 8'hb0);
    n = 0;
    while (display_on === 1'b1 && n < 80) begin
      step(1);
      n++;
    end
    chkv(29'(n > 20 && n < 40), 29'h1);
    rtc_enable = 1'b0;
    step(4);
    chkv(display_on, 1'b1);
    wr(8'h95, 8'h83);
    batt = 1'b1;
    wr(8'h95, 8'ha3);
    step(2);
    chkv(display_on, 1'b0);
    wr(8'h95, 8'h83);
    step(2);
    chkv({pump, display_on}, 2'h3);
    wr(8'h9c, 8'h65);
    step(2);
    chkv({bias, ladder, pump}, {6'h25, 2'h2});
    wr(8'h9c, 8'h00);
    wr(8'h95, 8'h03);
    step(2);
    chkv(pump, 1'b0);
    // With only the slow tick running, the scan moves only once selected.
    wr(8'h95, 8'h83);
    en2048 = 1'b0;
    step(8);
    c = com_active;
    step(40);
    chkv(com_active, c);
    wr(8'h9c, 8'h80);
    wait_com({c[2:0], c[3]});
    final_report();
  end
endmodule

// ===== segment_store.sv
// Segment data memory with a frozen display copy.
`timescale 1ns/1ps
module segment_store #(
  parameter int BYTES = lcd_pkg::SEG_BYTES
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  input  wire logic                 clear,
  input  wire logic                 wr_en,
  input  wire logic [5:0]           wr_addr,
  input  wire logic [7:0]           wr_data,
  input  wire logic [5:0]           rd_addr,
  output logic      [7:0]           rd_data,
  input  wire logic                 freeze,
  output logic      [BYTES*8-1:0]   shown
);

  logic [7:0]         mem_reg [BYTES];
  logic [BYTES*8-1:0] shown_reg;
  logic [BYTES*8-1:0] mem_flat;
  wire                wr_hit = wr_en && (int'(wr_addr) < BYTES);
  wire                rd_hit = int'(rd_addr) < BYTES;

  // Bytes outside the memory read as zero.
  assign rd_data = rd_hit ? mem_reg[rd_addr[3:0]] : 8'h00;
  assign shown   = shown_reg;

  // Power-on reset and the clear bit both empty the memory; nothing else
  // does, so contents survive low-power battery operation.
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < BYTES; i++) begin
      if (reset || clear) begin
        mem_reg[i] <= 8'h00;
      end else if (wr_hit && (int'(wr_addr) == i)) begin
        mem_reg[i] <= wr_data;
      end
    end
  end

  generate
    for (genvar b = 0; b < BYTES; b++) begin : g_flat
      assign mem_flat[b*8 +: 8] = mem_reg[b];
    end
  endgenerate

  // The glass sees a copy that only follows the memory while unfrozen, so
  // a multi-byte update appears all at once.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      shown_reg <= '0;
    end else if (!freeze) begin
      shown_reg <= mem_flat;
    end
  end

endmodule
